/* verilog/scc_pkg.sv */
// scc_pkg: field layout, enumerations and carrier types of the coefficient store.
// assumes one clock domain; image bits keep their stored bit numbering.
package scc_pkg;

  localparam int IMG_HI         = 99;
  localparam int IMG_LO         = 15;

  localparam int BGAIN_X8_BIT   = 29;
  localparam int BGAIN_HI       = 28;
  localparam int BGAIN_LO       = 15;
  localparam int BOFS_HI        = 43;
  localparam int BOFS_LO        = 30;
  localparam int TGAIN_HI       = 51;
  localparam int TGAIN_LO       = 44;
  localparam int TOFS_HI        = 59;
  localparam int TOFS_LO        = 52;
  localparam int TEMP_SENSOR_READING_HI        = 67;
  localparam int TEMP_SENSOR_READING_LO        = 60;
  localparam int GTC_HI         = 75;
  localparam int GTC_LO         = 68;
  localparam int OTC_HI         = 83;
  localparam int OTC_LO         = 76;
  localparam int OPT_INVERT_BIT = 87;
  localparam int OPT_GNEG_BIT   = 86;
  localparam int OPT_OX8_BIT    = 85;
  localparam int OPT_ONEG_BIT   = 84;
  localparam int SOT_SIGN_BIT   = 95;
  localparam int SOT_MAG_HI     = 94;
  localparam int SOT_MAG_LO     = 88;
  localparam int SOT_TGT_HI     = 99;
  localparam int SOT_TGT_LO     = 98;
  localparam int PAMP_HI        = 97;
  localparam int PAMP_LO        = 96;

  // x8 scaling is a left shift by this many bits
  localparam int X8_SHIFT       = 3;

  localparam logic [1:0] SOT_TGT_BRIDGE = 2'h0;
  localparam logic [1:0] SOT_TGT_GAIN   = 2'h1;
  localparam logic [1:0] SOT_TGT_OFFSET = 2'h2;
  localparam logic [1:0] SOT_TGT_BAD    = 2'h3;

  localparam logic [2:0] ROUTE_BRIDGE   = 3'h1;
  localparam logic [2:0] ROUTE_GAIN     = 3'h2;
  localparam logic [2:0] ROUTE_OFFSET   = 3'h4;
  localparam logic [2:0] ROUTE_NONE     = 3'h0;

  localparam logic [1:0] PAMP_CODE_6    = 2'h0;
  localparam logic [1:0] PAMP_CODE_24   = 2'h1;
  localparam logic [1:0] PAMP_CODE_12   = 2'h2;
  localparam logic [1:0] PAMP_CODE_48   = 2'h3;
  localparam logic [5:0] PAMP_GAIN_6    = 6'h06;
  localparam logic [5:0] PAMP_GAIN_24   = 6'h18;
  localparam logic [5:0] PAMP_GAIN_12   = 6'h0C;
  localparam logic [5:0] PAMP_GAIN_48   = 6'h30;

  typedef logic [IMG_HI:IMG_LO] scc_image_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_LOAD   = 4'h2,
    ST_SETTLE = 4'h4,
    ST_RUN    = 4'h8
  } scc_state_e;

  typedef struct packed {
    logic [16:0]        bridge_gain;   // unsigned, 11 fraction bits
    logic signed [13:0] bridge_offset;
    logic [7:0]         temp_gain;
    logic signed [7:0]  temp_offset;
    logic [7:0]         temp_sensor_reading_ref;
    logic signed [8:0]  gain_tempco;
    logic signed [11:0] offset_tempco;
    logic               bridge_invert;
    logic signed [10:0] second_order;
    logic [2:0]         sot_route;     // one-hot or zero: bridge, gain tc, offset tc
    logic [5:0]         preamp_gain;
  } scc_coeff_s;

endpackage

/* verilog/scc_coeff_store.sv */
// scc_coeff_store: nonvolatile coefficient image bits 99..15, decoded for the
// correction arithmetic. assumes the nv array and serial front end share ref_clk_in.
// Overview of operation
// - bridge gain in bits 29..15; low fourteen bits unsigned, range zero to below eight.
// - top bridge gain bit set multiplies the fourteen-bit gain value by eight.
// - bridge offset held in bits 43..30 as signed fourteen-bit value.
// - eight-bit temperature gain in bits 51..44 corrects raw temperature reading.
// - eight-bit temperature offset in bits 59..52 corrects raw temperature reading.
// - eight-bit raw temperature reference kept in bits 67..60.
// - gain tempco magnitude in bits 75..68, sign from option field.
// - offset tempco magnitude in bits 83..76, sign and scale from options.
// - option bit three set inverts bridge signal polarity.
// - option bit two set makes gain tempco negative.
// - option bit one scales offset tempco by eight, and second-order term targeting it.
// - option bit zero set makes offset tempco negative.
// - second-order term bits 95..88 are sign-magnitude, magnitude zero to 127.
// - selector 99..98 routes second-order term; code 11 must never be programmed.
// - preamp gain code 00/01/10/11 selects gain 6/24/12/48.
`timescale 1ns/10ps
module scc_coeff_store
  import scc_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       arst_n_in,
  input  wire scc_image_t nv_image_in,
  input  wire logic       prog_we_in,
  input  wire scc_image_t prog_data_in,
  output scc_image_t      image_out,
  output scc_coeff_s      coeff_out,
  output logic            coeff_valid_out,
  output logic            second_order_target_bad_out
);

  scc_state_e state_q;
  scc_state_e state_d;
  scc_image_t image_q;
  scc_coeff_s coeff_q;
  scc_coeff_s coeff_d;
  logic       valid_q;
  logic       sot_bad_q;

  // power-up sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:   state_d = ST_LOAD;
      ST_LOAD:   state_d = ST_SETTLE;
      ST_SETTLE: state_d = ST_RUN;
      ST_RUN:    state_d = ST_RUN;
      default:   state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // image: nv contents caught after release, then host writes
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      image_q <= '0;
    end else if (state_q == ST_LOAD) begin
      image_q <= nv_image_in;
    end else if (state_q == ST_RUN && prog_we_in) begin
      image_q <= prog_data_in;
    end
  end

  // field decode
  always_comb begin
    logic [11:0] otc_abs;
    logic [10:0] sot_abs;
    logic [8:0]  gtc_abs;
    otc_abs = '0;
    sot_abs = '0;
    gtc_abs = '0;
    coeff_d = '0;
    if (image_q[BGAIN_X8_BIT]) begin
      coeff_d.bridge_gain = {image_q[BGAIN_HI:BGAIN_LO], 3'h0};
    end else begin
      coeff_d.bridge_gain = {3'h0, image_q[BGAIN_HI:BGAIN_LO]};
    end
    coeff_d.bridge_offset = image_q[BOFS_HI:BOFS_LO];
    coeff_d.temp_gain     = image_q[TGAIN_HI:TGAIN_LO];
    coeff_d.temp_offset   = image_q[TOFS_HI:TOFS_LO];
    coeff_d.temp_sensor_reading_ref      = image_q[TEMP_SENSOR_READING_HI:TEMP_SENSOR_READING_LO];
    // gain tempco with sign
    gtc_abs = {1'h0, image_q[GTC_HI:GTC_LO]};
    coeff_d.gain_tempco = image_q[OPT_GNEG_BIT] ? 9'(~gtc_abs + 9'h001) : gtc_abs;
    // offset tempco with scale and sign
    if (image_q[OPT_OX8_BIT]) begin
      otc_abs = {1'h0, image_q[OTC_HI:OTC_LO], 3'h0};
    end else begin
      otc_abs = {4'h0, image_q[OTC_HI:OTC_LO]};
    end
    coeff_d.offset_tempco = image_q[OPT_ONEG_BIT] ? 12'(~otc_abs + 12'h001) : otc_abs;
    coeff_d.bridge_invert = image_q[OPT_INVERT_BIT];
    // second-order target routing
    case (image_q[SOT_TGT_HI:SOT_TGT_LO])
      SOT_TGT_BRIDGE: coeff_d.sot_route = ROUTE_BRIDGE;
      SOT_TGT_GAIN:   coeff_d.sot_route = ROUTE_GAIN;
      SOT_TGT_OFFSET: coeff_d.sot_route = ROUTE_OFFSET;
      default:        coeff_d.sot_route = ROUTE_NONE;
    endcase
    // sign-magnitude second-order term, x8 only toward offset tc
    if (image_q[OPT_OX8_BIT] && coeff_d.sot_route == ROUTE_OFFSET) begin
      sot_abs = {1'h0, image_q[SOT_MAG_HI:SOT_MAG_LO], 3'h0};
    end else begin
      sot_abs = {4'h0, image_q[SOT_MAG_HI:SOT_MAG_LO]};
    end
    coeff_d.second_order = image_q[SOT_SIGN_BIT] ? 11'(~sot_abs + 11'h001) : sot_abs;
    // preamp gain map
    case (image_q[PAMP_HI:PAMP_LO])
      PAMP_CODE_6:  coeff_d.preamp_gain = PAMP_GAIN_6;
      PAMP_CODE_24: coeff_d.preamp_gain = PAMP_GAIN_24;
      PAMP_CODE_12: coeff_d.preamp_gain = PAMP_GAIN_12;
      PAMP_CODE_48: coeff_d.preamp_gain = PAMP_GAIN_48;
      default:      coeff_d.preamp_gain = PAMP_GAIN_24;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      coeff_q <= '0;
    end else begin
      coeff_q <= coeff_d;
    end
  end

  // valid only once the loaded image has reached the decoded outputs
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= (state_q == ST_SETTLE) || (state_q == ST_RUN);
    end
  end

  // prohibited selector flagged; term then routed nowhere
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sot_bad_q <= 1'b0;
    end else begin
      sot_bad_q <= (state_q == ST_RUN) && (image_q[SOT_TGT_HI:SOT_TGT_LO] == SOT_TGT_BAD);
    end
  end

  assign image_out       = image_q;
  assign coeff_out       = coeff_q;
  assign coeff_valid_out = valid_q;
  assign second_order_target_bad_out = sot_bad_q;

  chk_gain_scale: assert property (
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    valid_q && $stable(image_q) && image_q[BGAIN_X8_BIT] |->
      coeff_q.bridge_gain == {image_q[BGAIN_HI:BGAIN_LO], 3'h0})
    else $error("bridge gain not scaled by eight");

  chk_gain_plain: assert property (
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    valid_q && $stable(image_q) && !image_q[BGAIN_X8_BIT] |->
      coeff_q.bridge_gain == {3'h0, image_q[BGAIN_HI:BGAIN_LO]})
    else $error("bridge gain mantissa wrong");

  chk_bridge_offset: assert property (
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    valid_q && $stable(image_q) |-> coeff_q.bridge_offset == image_q[BOFS_HI:BOFS_LO])
    else $error("bridge offset mismatch");

  chk_temp_fields: assert property (
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    valid_q && $stable(image_q) |->
      coeff_q.temp_gain == image_q[TGAIN_HI:TGAIN_LO] &&
      coeff_q.temp_offset == image_q[TOFS_HI:TOFS_LO] &&
      coeff_q.temp_sensor_reading_ref == image_q[TEMP_SENSOR_READING_HI:TEMP_SENSOR_READING_LO])
    else $error("temperature fields mismatch");

  chk_gain_tc_sign: assert property (
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    valid_q && $stable(image_q) |->
      coeff_q.gain_tempco + (image_q[OPT_GNEG_BIT] ? 9'(image_q[GTC_HI:GTC_LO]) :
      9'(-$signed({1'b0, image_q[GTC_HI:GTC_LO]}))) == 9'h000)
    else $error("gain tempco sign wrong");

  chk_offset_tc: assert property (
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    valid_q && $stable(image_q) && image_q[OPT_OX8_BIT] && !image_q[OPT_ONEG_BIT] |->
      coeff_q.offset_tempco == {1'h0, image_q[OTC_HI:OTC_LO], 3'h0})
    else $error("offset tempco scale wrong");

  chk_offset_tc_neg: assert property (
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    valid_q && $stable(image_q) && image_q[OPT_ONEG_BIT] && image_q[OTC_HI:OTC_LO] != 8'h00 |->
      coeff_q.offset_tempco[11])
    else $error("offset tempco not negative");

  chk_polarity_flip: assert property (
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    valid_q && $stable(image_q) |-> coeff_q.bridge_invert == image_q[OPT_INVERT_BIT])
    else $error("polarity invert mismatch");

  chk_sot_sign: assert property (
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    valid_q && $stable(image_q) && image_q[SOT_MAG_HI:SOT_MAG_LO] != 7'h00 |->
      coeff_q.second_order[10] == image_q[SOT_SIGN_BIT])
    else $error("second order sign wrong");

  chk_sot_route: assert property (
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    valid_q && $stable(image_q) |->
      $onehot0(coeff_q.sot_route) &&
      ((coeff_q.sot_route == ROUTE_NONE) == (image_q[SOT_TGT_HI:SOT_TGT_LO] == SOT_TGT_BAD)))
    else $error("second order routing wrong");

  chk_preamp_map: assert property (
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    valid_q && $stable(image_q) && image_q[PAMP_HI:PAMP_LO] == PAMP_CODE_12 |->
      coeff_q.preamp_gain == PAMP_GAIN_12)
    else $error("preamp gain map wrong");

  chk_load_first: assert property (
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    state_q == ST_LOAD |=> !valid_q ##1 valid_q && coeff_q == $past(coeff_d))
    else $error("valid before nv load decoded");

  chk_write_hold: assert property (
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    state_q == ST_RUN && !prog_we_in |=> $stable(image_q))
    else $error("image changed without a write");

endmodule

/* bench/scc_host_model.sv */
// scc_host_model: calibration host side, supplies the nv image and whole-image writes.
// assumes writes are launched on the falling edge of ref_clk_in.
`timescale 1ns/10ps
module scc_host_model
  import scc_pkg::*;
#(
  parameter scc_image_t NV_INIT = '0
)
(
  input  wire logic ref_clk_in,
  output scc_image_t nv_image_out,
  output logic       prog_we_out,
  output scc_image_t prog_data_out
);
  initial begin
    nv_image_out  = NV_INIT;
    prog_we_out   = 1'b0;
    prog_data_out = '0;
  end
  // only the raw image is driven here, the device stores it and decodes every field
  task automatic put(input scc_image_t img, input logic last);
    @(negedge ref_clk_in);
    prog_we_out   = 1'b1;
    prog_data_out = img;
    if (last) begin
      @(negedge ref_clk_in);
      prog_we_out   = 1'b0;
      // released data bus does not keep the old value
      prog_data_out = ~img;
    end
  endtask
endmodule

/* bench/scc_coeff_store_test.sv */
// scc_coeff_store_test: register-level bench of the coefficient store.
// assumes scc_host_model drives the nv image and the write port.
`timescale 1ns/10ps
module scc_coeff_store_test;
  import scc_pkg::*;
  localparam scc_image_t NV = {2'h0, 2'h1, 8'hC0, 4'h5, 8'h33, 8'h44, 8'h80, 8'hF0,
                               8'h80, 14'h3FFC, 15'h4800};
  logic       ref_clk_in;
  logic       arst_n_in;
  logic       prog_we_in;
  logic       coeff_valid_out;
  logic       second_order_target_bad_out;
  scc_image_t nv_image_in;
  scc_image_t prog_data_in;
  scc_image_t image_out;
  scc_coeff_s coeff_out;
  scc_image_t tv [4];
  int         failures;
  int         n_tests;

  scc_host_model #(.NV_INIT(NV)) host (
    .ref_clk_in   (ref_clk_in),
    .nv_image_out (nv_image_in),
    .prog_we_out  (prog_we_in),
    .prog_data_out(prog_data_in)
  );
  scc_coeff_store DUT (
    .ref_clk_in     (ref_clk_in),
    .arst_n_in      (arst_n_in),
    .nv_image_in    (nv_image_in),
    .prog_we_in     (prog_we_in),
    .prog_data_in   (prog_data_in),
    .image_out      (image_out),
    .coeff_out      (coeff_out),
    .coeff_valid_out(coeff_valid_out),
    .second_order_target_bad_out(second_order_target_bad_out)
  );

  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end

  function automatic scc_coeff_s dec(input scc_image_t m);
    scc_coeff_s  c;
    logic [11:0] o;
    logic [10:0] s;
    c.bridge_gain   = m[29] ? {m[28:15], 3'h0} : {3'h0, m[28:15]};
    c.bridge_offset = m[43:30];
    c.temp_gain     = m[51:44];
    c.temp_offset   = m[59:52];
    c.temp_sensor_reading_ref      = m[67:60];
    c.gain_tempco   = m[86] ? 9'h000 - {1'h0, m[75:68]} : {1'h0, m[75:68]};
    o               = m[85] ? {1'h0, m[83:76], 3'h0} : {4'h0, m[83:76]};
    c.offset_tempco = m[84] ? 12'h000 - o : o;
    c.bridge_invert = m[87];
    s = (m[85] && m[99:98] == 2'h2) ? {1'h0, m[94:88], 3'h0} : {4'h0, m[94:88]};
    c.second_order  = m[95] ? 11'h000 - s : s;
    case (m[99:98])
      2'h0: c.sot_route = 3'h1;
      2'h1: c.sot_route = 3'h2;
      2'h2: c.sot_route = 3'h4;
      default: c.sot_route = 3'h0;
    endcase
    case (m[97:96])
      2'h0: c.preamp_gain = 6'h06;
      2'h1: c.preamp_gain = 6'h18;
      2'h2: c.preamp_gain = 6'h0C;
      default: c.preamp_gain = 6'h30;
    endcase
    return c;
  endfunction

  task automatic cmp_img(input string what, input scc_image_t exp);
    n_tests++;
    if (image_out !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, image_out);
    end
  endtask
  task automatic cmp_coeff(input string what, input scc_coeff_s exp);
    n_tests++;
    if (coeff_out !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, coeff_out);
    end
  endtask
  task automatic cmp_bit(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic do_reset();
    int n;
    @(negedge ref_clk_in);
    arst_n_in = 1'b0;
    repeat (10) @(negedge ref_clk_in);
    cmp_bit("valid_in_reset", 1'b0, coeff_valid_out);
    cmp_img("image_in_reset", '0);
    arst_n_in = 1'b1;
    n = 0;
    while (coeff_valid_out !== 1'b1 && n < 8) begin
      @(negedge ref_clk_in);
      n++;
    end
    if (n >= 8) begin
      failures++;
      $display("Error valid expected 1 seen %b", coeff_valid_out);
      wrap_up();
    end
    cmp_bit("load_latency", 1'b1, n == 3);
    cmp_img("nv_image", NV);
    cmp_coeff("nv_decode", dec(NV));
    $display("test reset load done");
  endtask

  initial begin
    failures  = 0;
    n_tests   = 0;
    arst_n_in = 1'b0;
    tv[0] = {2'h1, 2'h0, 8'h85, 4'hF, 8'hFF, 8'h01, 8'h12, 8'h80, 8'h7F, 14'h2000, 15'h3FFF};
    tv[1] = {2'h2, 2'h2, 8'hFF, 4'h2, 8'h81, 8'hFF, 8'hAB, 8'h7F, 8'h00, 14'h1FFF, 15'h7FFF};
    tv[2] = {2'h3, 2'h3, 8'h7F, 4'h8, 8'h00, 8'h80, 8'h01, 8'hC3, 8'h55, 14'h0001, 15'h0000};
    tv[3] = {2'h2, 2'h1, 8'h85, 4'h1, 8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 14'h3FFF, 15'h4001};
    do_reset();
    for (int i = 0; i < 4; i++) begin
      host.put(tv[i], 1'b1);
      cmp_img("image_write", tv[i]);
      @(negedge ref_clk_in);
      // gain x8, offsets, tempco signs, scaling, sot decode and routing, preamp map
      cmp_coeff("coeff_decode", dec(tv[i]));
      cmp_bit("second_order_target_bad", tv[i][99:98] == 2'h3, second_order_target_bad_out);
    end
    $display("test field decode done");
    host.put(tv[0], 1'b0);
    host.put(tv[1], 1'b1);
    cmp_img("last_write_wins", tv[1]);
    repeat (5) @(negedge ref_clk_in);
    cmp_img("image_holds", tv[1]);
    cmp_coeff("coeff_holds", dec(tv[1]));
    $display("test back to back done");
    do_reset();
    wrap_up();
  end
endmodule
